// [hw/fbi_pkg.sv]
// constants and types for the fieldbus input image and diagnostics block
// ----------------------------------------------------------------------
// Summary of operation
// ----------------------------------------------------------------------
// Summary of operation
// - sixteen inputs form two image bytes, inputs 1-8 low byte, 9-16 high byte
// - 32-bit status word, bit 5 undervoltage, bit 4 overload, others reserved
// - emergency messages are sent unprompted on fault events, never confirmed
// - message is error code two bytes, error register one byte, five diag bytes
// - codes 3001/3002/3003 set bit 2, 4001 sets bit 4, diag byte two 01/02/03/06
// - message on fault set and clear; clear sends code 0000, clears bit unless another supply fault is still active, keeps diag
// - master picks buffer-event or clock-event update of process data
// - buffer-event mode is default, sampling free-running at shortest cycle
// - clock-event mode outputs and reads inputs fixed delays after each sync event
// - writing 1 to object 2F00 restores default settings at next power-on
// - multi-byte data travel least significant byte first
// - firmware image accepted over the file-access mailbox service
package fbi_pkg;
  localparam int          IMG_BYTES        = 2;
  localparam int          STAT_UNDERV_BIT  = 5;
  localparam int          STAT_OVERLD_BIT  = 4;
  localparam int          EMCY_BYTES       = 8;
  localparam int          NUM_FAULTS       = 4;
  localparam logic [15:0] CODE_CLEAR       = 16'h0000;
  localparam logic [15:0] CODE_OVERCUR     = 16'h3001;
  localparam logic [15:0] CODE_SURGE       = 16'h3002;
  localparam logic [15:0] CODE_UNDERV      = 16'h3003;
  localparam logic [15:0] CODE_OVERTEMP    = 16'h4001;
  localparam int          ERREG_SUPPLY_BIT = 2;
  localparam int          ERREG_TEMP_BIT   = 4;
  localparam logic [7:0]  DIAG_OVERCUR     = 8'h01;
  localparam logic [7:0]  DIAG_SURGE       = 8'h02;
  localparam logic [7:0]  DIAG_UNDERV      = 8'h03;
  localparam logic [7:0]  DIAG_OVERTEMP    = 8'h06;
  localparam logic [15:0] RESTORE_INDEX    = 16'h2F00;
  localparam logic [31:0] RESTORE_VALUE    = 32'h0000_0001;
  localparam int          CLK_MHZ          = 40;
  localparam int          OUT_DELAY_NS     = 1000;
  localparam int          IN_DELAY_NS      = 500;
  localparam int          FREE_PERIOD_NS   = 1000;
  localparam logic [15:0] OUT_DELAY_CYC    = 16'((OUT_DELAY_NS * CLK_MHZ) / 1000);
  localparam logic [15:0] IN_DELAY_CYC     = 16'((IN_DELAY_NS * CLK_MHZ) / 1000);
  localparam logic [15:0] FREE_PERIOD_CYC  = 16'((FREE_PERIOD_NS * CLK_MHZ) / 1000);
  localparam logic        MODE_BUFFER      = 1'b0;
  localparam logic        MODE_CLOCK       = 1'b1;
  typedef enum logic [2:0] {
    EM_IDLE = 3'b001,
    EM_LOAD = 3'b010,
    EM_SEND = 3'b100
  } fbi_em_state_t;
endpackage

// [hw/fbi_delay_timer.sv]
// one-shot delay counter started by an event
`timescale 1ns/100ps
module fbi_delay_timer
  import fbi_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [15:0] delay,
  output logic             fire
);
  logic [15:0] cnt_reg;
  logic        run_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_reg <= 16'h0000;
      run_reg <= 1'b0;
      fire    <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (start) begin
        cnt_reg <= delay;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        if (cnt_reg <= 16'h0001) begin
          run_reg <= 1'b0;
          fire    <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 16'h0001;
        end
      end
    end
  end
endmodule

// [hw/fbi_emcy_ser.sv]
// byte serialiser for one eight-byte emergency message
`timescale 1ns/100ps
module fbi_emcy_ser
  import fbi_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic [63:0] msg,
  output logic [7:0]       byte_data,
  output logic             byte_valid,
  output logic             byte_last,
  output logic             busy
);
  logic [63:0] sh_reg;
  logic [3:0]  left_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sh_reg     <= 64'h0;
      left_reg   <= 4'h0;
      byte_data  <= 8'h00;
      byte_valid <= 1'b0;
      byte_last  <= 1'b0;
      busy       <= 1'b0;
    end else begin
      byte_valid <= 1'b0;
      byte_last  <= 1'b0;
      if (load && !busy) begin
        sh_reg   <= msg;
        left_reg <= 4'(EMCY_BYTES);
        busy     <= 1'b1;
      end else if (busy) begin
        byte_data  <= sh_reg[7:0];
        byte_valid <= 1'b1;
        byte_last  <= (left_reg == 4'h1);
        sh_reg     <= {8'h00, sh_reg[63:8]};
        left_reg   <= left_reg - 4'h1;
        busy       <= (left_reg != 4'h1);
      end
    end
  end
endmodule

// [hw/fbi_top.sv]
// input image, status word, emergency messages and sync control
`timescale 1ns/100ps
module fbi_top
  import fbi_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [15:0] input_channel,
  input  wire logic        sup_underv,
  input  wire logic        sup_overld,
  input  wire logic        sup_surge,
  input  wire logic        over_temp,
  input  wire logic        mode_sel,
  input  wire logic        buf_event,
  input  wire logic        sync0_event,
  input  wire logic        obj_wr,
  input  wire logic [15:0] obj_index,
  input  wire logic [31:0] obj_data,
  input  wire logic        fw_valid,
  input  wire logic [7:0]  fw_byte,
  input  wire logic        fw_last,
  output logic [7:0]       tx_byte,
  output logic             tx_valid,
  output logic             tx_last,
  output logic [15:0]      image_reg,
  output logic [31:0]      status_reg,
  output logic             pd_out_strobe,
  output logic [7:0]       emcy_byte,
  output logic             emcy_valid,
  output logic             emcy_last,
  output logic             restore_reg,
  output logic [7:0]       fw_data,
  output logic             fw_strobe,
  output logic             fw_done,
  output logic             mode_reg
);
  // ----------------------------------------------------------------------
  // sync mode and sampling triggers
  // ----------------------------------------------------------------------
  logic [15:0] free_cnt_reg;
  logic        free_tick;
  logic        in_fire;
  logic        out_fire;
  logic        sample;
  logic        sync_start;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_reg <= MODE_BUFFER;
    end else begin
      mode_reg <= mode_sel;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      free_cnt_reg <= 16'h0000;
    end else if (free_cnt_reg >= FREE_PERIOD_CYC - 16'h0001) begin
      free_cnt_reg <= 16'h0000;
    end else begin
      free_cnt_reg <= free_cnt_reg + 16'h0001;
    end
  end

  assign free_tick  = (free_cnt_reg == 16'h0000);
  assign sync_start = (mode_reg == MODE_CLOCK) && sync0_event;
  assign sample     = (mode_reg == MODE_BUFFER) ? free_tick : in_fire;

  fbi_delay_timer u_in_dly (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (sync_start),
    .delay   (IN_DELAY_CYC),
    .fire    (in_fire)
  );

  fbi_delay_timer u_out_dly (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (sync_start),
    .delay   (OUT_DELAY_CYC),
    .fire    (out_fire)
  );

  // ----------------------------------------------------------------------
  // input image and status word
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      image_reg <= 16'h0000;
    end else if (sample) begin
      image_reg <= input_channel;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_reg <= 32'h0000_0000;
    end else if (sample) begin
      status_reg <= 32'h0000_0000;
      status_reg[STAT_UNDERV_BIT] <= sup_underv;
      status_reg[STAT_OVERLD_BIT] <= sup_overld;
    end
  end

  // ----------------------------------------------------------------------
  // transmit process data: image then status, low byte first
  // ----------------------------------------------------------------------
  logic [47:0] tx_sh_reg;
  logic [2:0]  tx_left_reg;
  logic        pd_go;

  assign pd_go = (mode_reg == MODE_BUFFER) ? buf_event : out_fire;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pd_out_strobe <= 1'b0;
    end else begin
      pd_out_strobe <= pd_go;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_sh_reg     <= 48'h0;
      tx_left_reg   <= 3'h0;
      tx_byte       <= 8'h00;
      tx_valid      <= 1'b0;
      tx_last       <= 1'b0;
    end else begin
      tx_valid      <= 1'b0;
      tx_last       <= 1'b0;
      if (pd_go && tx_left_reg == 3'h0) begin
        tx_sh_reg   <= {status_reg, image_reg};
        tx_left_reg <= 3'h6;
      end else if (tx_left_reg != 3'h0) begin
        tx_byte     <= tx_sh_reg[7:0];
        tx_valid    <= 1'b1;
        tx_last     <= (tx_left_reg == 3'h1);
        tx_sh_reg   <= {8'h00, tx_sh_reg[47:8]};
        tx_left_reg <= tx_left_reg - 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // emergency messages
  // ----------------------------------------------------------------------
  logic [NUM_FAULTS-1:0] flt_now;
  logic [NUM_FAULTS-1:0] flt_reg;
  logic [NUM_FAULTS-1:0] pend_reg;
  logic [7:0]            erreg_reg;
  logic [7:0]            diag_reg;
  logic [63:0]           msg_reg;
  logic                  ser_load;
  logic                  ser_busy;
  logic [1:0]            pick;
  logic                  pick_ok;
  fbi_em_state_t         em_state;
  logic [7:0]            erreg_mask;
  logic [7:0]            erreg_set;
  logic [7:0]            erreg_clr;
  logic                  clr_ok;

  assign flt_now = {over_temp, sup_underv, sup_surge, sup_overld};

  always_comb begin
    pick    = 2'd0;
    pick_ok = 1'b0;
    for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
      if (pend_reg[i]) begin
        pick    = 2'(i);
        pick_ok = 1'b1;
      end
    end
  end

  function automatic logic [15:0] code_of(input logic [1:0] k);
    case (k)
      2'd0:    code_of = CODE_OVERCUR;
      2'd1:    code_of = CODE_SURGE;
      2'd2:    code_of = CODE_UNDERV;
      default: code_of = CODE_OVERTEMP;
    endcase
  endfunction

  function automatic logic [7:0] diag_of(input logic [1:0] k);
    case (k)
      2'd0:    diag_of = DIAG_OVERCUR;
      2'd1:    diag_of = DIAG_SURGE;
      2'd2:    diag_of = DIAG_UNDERV;
      default: diag_of = DIAG_OVERTEMP;
    endcase
  endfunction

  always_comb begin
    erreg_mask = 8'h00;
    if (pick == 2'd3) begin
      erreg_mask[ERREG_TEMP_BIT] = 1'b1;
    end else begin
      erreg_mask[ERREG_SUPPLY_BIT] = 1'b1;
    end
    clr_ok    = (pick == 2'd3) || (flt_reg[2:0] == 3'h0);
    erreg_set = erreg_reg | erreg_mask;
    erreg_clr = clr_ok ? (erreg_reg & ~erreg_mask) : erreg_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      erreg_reg <= 8'h00;
      diag_reg  <= 8'h00;
      msg_reg   <= 64'h0;
      ser_load  <= 1'b0;
      em_state  <= EM_IDLE;
    end else begin
      ser_load <= 1'b0;
      case (em_state)
        EM_IDLE: begin
          if (pick_ok && !ser_busy) begin
            em_state <= EM_LOAD;
          end
        end
        EM_LOAD: begin
          if (flt_reg[pick]) begin
            erreg_reg <= erreg_set;
            diag_reg  <= diag_of(pick);
            msg_reg   <= {24'h0, diag_of(pick), 8'h00,
                          erreg_set, code_of(pick)};
          end else begin
            erreg_reg <= erreg_clr;
            msg_reg   <= {24'h0, diag_reg, 8'h00, erreg_clr, CODE_CLEAR};
          end
          ser_load <= 1'b1;
          em_state <= EM_SEND;
        end
        EM_SEND: begin
          if (!ser_load && !ser_busy) begin
            em_state <= EM_IDLE;
          end
        end
        default: em_state <= EM_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flt_reg <= '0;
    end else begin
      flt_reg <= flt_now;
    end
  end

  // change events set pending, set wins over the clear of the picked one
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pend_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_FAULTS; i++) begin
        if (flt_now[i] != flt_reg[i]) begin
          pend_reg[i] <= 1'b1;
        end else if (em_state == EM_LOAD && pick == 2'(i)) begin
          pend_reg[i] <= 1'b0;
        end
      end
    end
  end

  fbi_emcy_ser u_ser (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .load       (ser_load),
    .msg        (msg_reg),
    .byte_data  (emcy_byte),
    .byte_valid (emcy_valid),
    .byte_last  (emcy_last),
    .busy       (ser_busy)
  );

  // ----------------------------------------------------------------------
  // restore object and firmware download
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      restore_reg <= 1'b0;
    end else if (obj_wr && obj_index == RESTORE_INDEX) begin
      restore_reg <= (obj_data == RESTORE_VALUE);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fw_strobe <= 1'b0;
      fw_done   <= 1'b0;
    end else begin
      fw_strobe <= fw_valid;
      fw_done   <= fw_valid && fw_last;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fw_data <= 8'h00;
    end else if (fw_valid) begin
      fw_data <= fw_byte;
    end
  end
endmodule

// [bench/fbi_master_model.sv]
// master-side model collecting the cyclic and emergency byte streams
`timescale 1ns/100ps
module fbi_master_model (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic [7:0] tx_byte,
  input wire logic       tx_valid,
  input wire logic [7:0] emcy_byte,
  input wire logic       emcy_valid
);
  logic [7:0] txq[$];
  logic [7:0] emq[$];
  // bytes taken as they come, nothing sent back
  always @(posedge ref_clk) begin
    if (!rst && emcy_valid) emq.push_back(emcy_byte);
    if (!rst && tx_valid) txq.push_back(tx_byte);
  end
endmodule

// [bench/fbi_assertions.sv]
// port checker for the fieldbus input block
`timescale 1ns/100ps
module fbi_assertions
  import fbi_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        buf_event,
  input wire logic        sync0_event,
  input wire logic        obj_wr,
  input wire logic [15:0] obj_index,
  input wire logic [31:0] obj_data,
  input wire logic        fw_valid,
  input wire logic [7:0]  fw_byte,
  input wire logic        tx_valid,
  input wire logic        tx_last,
  input wire logic [31:0] status_reg,
  input wire logic        pd_out_strobe,
  input wire logic [7:0]  emcy_byte,
  input wire logic        emcy_valid,
  input wire logic        emcy_last,
  input wire logic        restore_reg,
  input wire logic [7:0]  fw_data,
  input wire logic        fw_strobe,
  input wire logic        mode_reg
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_tx_run; tx_valid [*6]; endsequence
  sequence s_em_run; emcy_valid [*8]; endsequence
  sequence s_em_sup; $rose(emcy_valid) ##1 emcy_byte == 8'h30; endsequence
  sequence s_em_tmp; $rose(emcy_valid) ##1 emcy_byte == 8'h40; endsequence
  sequence s_em_clr; $rose(emcy_valid) && emcy_byte == 8'h00 ##1 emcy_byte == 8'h00; endsequence
  a_status_rsvd_zero: assert property (status_reg[3:0] == 4'h0 && status_reg[31:6] == 26'h0)
    else $error("reserved status bits set");
  a_tx_frame_len: assert property ($rose(tx_valid) |-> s_tx_run)
    else $error("tx frame short");
  a_tx_last_pos: assert property ($rose(tx_valid) |-> ##5 tx_last)
    else $error("tx last misplaced");
  a_emcy_frame_len: assert property ($rose(emcy_valid) |-> s_em_run)
    else $error("emcy frame short");
  a_emcy_last_pos: assert property ($rose(emcy_valid) |-> ##7 emcy_last)
    else $error("emcy last misplaced");
  a_emcy_supply_bit: assert property (s_em_sup |=> emcy_byte[ERREG_SUPPLY_BIT])
    else $error("supply error bit missing");
  a_emcy_temp_bit: assert property (s_em_tmp |=> emcy_byte[ERREG_TEMP_BIT])
    else $error("temperature error bit missing");
  a_emcy_diag_kept: assert property (s_em_clr |-> ##3 emcy_byte != 8'h00)
    else $error("diag byte lost on clear");
  a_restore_set: assert property (obj_wr && obj_index == RESTORE_INDEX
    && obj_data == RESTORE_VALUE |=> restore_reg)
    else $error("restore flag not set");
  a_buf_strobe: assert property (buf_event && !mode_reg |=> pd_out_strobe)
    else $error("buffer event strobe missing");
  a_sync_out_delay: assert property (sync0_event && mode_reg |-> ##[39:43] pd_out_strobe)
    else $error("sync output delay wrong");
  a_fw_copy: assert property (fw_valid |=> fw_strobe && fw_data == $past(fw_byte))
    else $error("firmware byte not passed");
endmodule
bind fbi_top fbi_assertions u_chk (.ref_clk, .rst, .buf_event, .sync0_event, .obj_wr,
  .obj_index, .obj_data, .fw_valid, .fw_byte, .tx_valid, .tx_last, .status_reg,
  .pd_out_strobe, .emcy_byte, .emcy_valid, .emcy_last, .restore_reg, .fw_data,
  .fw_strobe, .mode_reg);

// [bench/fbi_top_tb_top.sv]
// self-checking bench for the fieldbus input block
`timescale 1ns/100ps
`define CHK(a, b) begin \
  total_checks++; \
  if ((a) !== (b)) begin \
    error_cnt++; \
    $display("mismatch at %0t: got %h expected %h", $time, a, b); \
  end \
end
module fbi_top_tb_top;
  import fbi_pkg::*;
  logic        ref_clk = 1'b0, rst = 1'b1;
  logic [15:0] input_channel = 16'h0000, obj_index = 16'h0000;
  logic        sup_underv = 1'b0, sup_overld = 1'b0, sup_surge = 1'b0, over_temp = 1'b0;
  logic        mode_sel = 1'b0, buf_event = 1'b0, sync0_event = 1'b0, obj_wr = 1'b0;
  logic [31:0] obj_data = 32'h0000_0000;
  logic        fw_valid = 1'b0, fw_last = 1'b0;
  logic [7:0]  fw_byte = 8'h00;
  logic [7:0]  tx_byte, emcy_byte, fw_data;
  logic        tx_valid, tx_last, pd_out_strobe, emcy_valid, emcy_last;
  logic        restore_reg, fw_strobe, fw_done, mode_reg;
  logic [15:0] image_reg;
  logic [31:0] status_reg;
  int          error_cnt = 0, total_checks = 0, n, m;
  // rows: input levels, undervoltage, overload, expected status byte
  logic [25:0] rows [4] = '{{16'h0000, 2'b00, 8'h00}, {16'hA55A, 2'b10, 8'h20},
                            {16'h8001, 2'b01, 8'h10}, {16'hFFFF, 2'b11, 8'h30}};
  logic [15:0] cd [4] = '{CODE_OVERCUR, CODE_SURGE, CODE_UNDERV, CODE_OVERTEMP};
  logic [7:0]  dg [4] = '{DIAG_OVERCUR, DIAG_SURGE, DIAG_UNDERV, DIAG_OVERTEMP};
  fbi_top DUT (.ref_clk, .rst, .input_channel, .sup_underv, .sup_overld, .sup_surge,
    .over_temp, .mode_sel, .buf_event, .sync0_event, .obj_wr, .obj_index, .obj_data,
    .fw_valid, .fw_byte, .fw_last, .tx_byte, .tx_valid, .tx_last, .image_reg,
    .status_reg, .pd_out_strobe, .emcy_byte, .emcy_valid, .emcy_last, .restore_reg,
    .fw_data, .fw_strobe, .fw_done, .mode_reg);
  fbi_master_model u_mst (.ref_clk, .rst, .tx_byte, .tx_valid, .emcy_byte, .emcy_valid);
  always #12.5 ref_clk = ~ref_clk;
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk_bytes(input logic [63:0] exp, input int k, input bit em);
    logic [7:0] got;
    `CHK(em ? u_mst.emq.size() : u_mst.txq.size(), k)
    for (int i = 0; i < k; i++) begin
      got = em ? u_mst.emq[i] : u_mst.txq[i];
      `CHK(got, exp[8*i +: 8])
    end
  endtask
  task automatic wr_obj(input logic [15:0] idx, input logic [31:0] val);
    @(posedge ref_clk);
    obj_wr <= 1'b1;
    obj_index <= idx;
    obj_data <= val;
    @(posedge ref_clk);
    obj_wr <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask
  initial begin
    tick(20000);
    error_cnt++;
    wrap_up;
  end
  initial begin
    tick(8);
    rst <= 1'b0;
    tick(1);
    #1;
    `CHK(mode_reg, MODE_BUFFER)
    `CHK(tx_valid, 1'b0)
    `CHK(restore_reg, 1'b0)
    for (int r = 0; r < 4; r++) begin
      @(posedge ref_clk);
      {input_channel, sup_underv, sup_overld} <= rows[r][25:8];
      tick(45);
      u_mst.txq.delete();
      buf_event <= 1'b1;
      @(posedge ref_clk);
      buf_event <= 1'b0;
      tick(12);
      `CHK(image_reg, rows[r][25:10])
      `CHK(status_reg, {24'h0, rows[r][7:0]})
      chk_bytes({24'h0, rows[r][7:0], rows[r][25:10]}, 6, 1'b0);
    end
    @(posedge ref_clk);
    {input_channel, sup_underv, sup_overld} <= 18'h0;
    tick(40);
    for (int i = 0; i < 4; i++) begin
      u_mst.emq.delete();
      {over_temp, sup_underv, sup_surge, sup_overld} <= 4'(1 << i);
      tick(30);
      chk_bytes({24'h0, dg[i], 8'h00, 8'(i < 3 ? 8'h04 : 8'h10), cd[i]}, 8, 1'b1);
      u_mst.emq.delete();
      {over_temp, sup_underv, sup_surge, sup_overld} <= 4'h0;
      tick(30);
      chk_bytes({24'h0, dg[i], 8'h00, 8'h00, CODE_CLEAR}, 8, 1'b1);
    end
    wr_obj(16'h1234, RESTORE_VALUE);
    `CHK(restore_reg, 1'b0)
    wr_obj(RESTORE_INDEX, RESTORE_VALUE);
    `CHK(restore_reg, 1'b1)
    wr_obj(RESTORE_INDEX, 32'h0000_0002);
    `CHK(restore_reg, 1'b0)
    @(posedge ref_clk);
    fw_valid <= 1'b1;
    fw_byte <= 8'hA5;
    fw_last <= 1'b1;
    @(posedge ref_clk);
    fw_valid <= 1'b0;
    fw_last <= 1'b0;
    #1;
    `CHK({fw_strobe, fw_done, fw_data}, 10'h3A5)
    @(posedge ref_clk);
    mode_sel <= MODE_CLOCK;
    tick(3);
    `CHK(mode_reg, MODE_CLOCK)
    u_mst.txq.delete();
    sync0_event <= 1'b1;
    input_channel <= 16'h3C3C;
    @(posedge ref_clk);
    sync0_event <= 1'b0;
    #1;
    n = 1;
    m = 0;
    while (pd_out_strobe !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (m == 0 && image_reg === 16'h3C3C) m = n;
    end
    `CHK((n >= 41 && n <= 43), 1'b1)
    `CHK((m >= 21 && m <= 23), 1'b1)
    tick(12);
    `CHK(u_mst.txq.size(), 6)
    chk_bytes({32'h0, 16'h3C3C}, 6, 1'b0);
    rst <= 1'b1;
    tick(2);
    #1;
    `CHK({mode_reg, image_reg, tx_valid}, 18'h0)
    wrap_up;
  end
endmodule
